// File: logic/cmd_status_pkg.sv
// Constants and carrier types for the bridge command and status registers
package cmd_status_pkg;
   // ----------------------------------------
   // Offsets and reset values
   // ----------------------------------------
   localparam logic [7:0] CMD_OFFSET = 8'h04;
   localparam logic [7:0] STS_OFFSET = 8'h06;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] STS_RESET = 16'h0010;
   // Writable command bits: 8, 6, 4, 2, 1, 0
   localparam logic [15:0] CMD_WMASK = 16'h0157;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ERR_FWD_BIT = 8;
   localparam int PAR_RESP_BIT = 6;
   localparam int WR_INV_BIT = 4;
   localparam int MASTER_BIT = 2;
   localparam int MEM_BIT = 1;
   localparam int IO_BIT = 0;
   localparam int DET_PAR_BIT = 15;
   localparam int SIG_ERR_BIT = 14;
   localparam int MPAR_BIT = 8;
   // Status bits that are sticky and cleared by writing one
   localparam logic [15:0] STS_W1C_MASK = 16'hC100;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [1:0] byteEn;
      logic [15:0] wrData;
   } cfg_req_t;

   typedef struct packed {
      logic downMemReq;
      logic downIoReq;
      logic downMemWrite;
      logic poisonedRx;
      logic poisonedCpl;
      logic poisonedWrite;
      logic secSerr;
      logic secMemIoReq;
      logic upReq;
   } bridge_evt_t;

   typedef struct packed {
      logic memForward;
      logic memUnsupported;
      logic ioForward;
      logic ioUnsupported;
      logic useWriteInvalidate;
      logic forcedBadParity;
      logic claimSecondary;
      logic upReqGrant;
      logic errMsgSend;
      logic specialClaim;
   } bridge_ctl_t;
endpackage

// File: logic/status_flags.sv
// Sticky status flags with write-one-to-clear
`timescale 1ns/100ps
module status_flags
   import cmd_status_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] setBits,
   input wire logic [WIDTH-1:0] clearBits,
   output logic [WIDTH-1:0] flags
);
   // Set wins over a clear in the same cycle so no event is lost
   wire logic [WIDTH-1:0] next_flags = (flags & ~clearBits) | setBits;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule

// File: logic/bridge_command_status_regs.sv
// Primary command and status registers of the bridge with their gating
//
// Function
// - Command bits 15 to 11 are reserved and read zero.
// - Interrupt disable bit is read-only zero; bridge raises no interrupts.
// - Fast back-to-back enable always reads zero.
// - Error forward enable is read/write, reset zero, gates error messages.
// - Stepping control bit is hardwired zero.
// - Parity response enable, reset zero, gates master parity flag on poison.
// - Poisoned data goes to PCI with bad parity regardless of enable.
// - Palette snoop enable always reads zero.
// - Write-invalidate enable promotes downstream memory writes when set and memory decode is set.
// - Special cycle enable reads zero; special cycles never claimed.
// - Bus master enable set allows upstream requests and secondary forwarding.
// - Bus master enable clear blocks upstream requests and secondary claims.
// - Memory decode clear answers memory requests unsupported; set forwards.
// - I/O decode clear answers I/O requests unsupported; set forwards.
// - Status register at 06h resets to 0010h.
// - Command register at 04h resets to zero.
// - Status bit 8 sets on poisoned completion or write when enabled.
// - Status bit 14 sets when error message sent while forwarding enabled.
`timescale 1ns/100ps
module bridge_command_status_regs
   import cmd_status_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire cfg_req_t cfgReq,
   output logic [15:0] cfgRdData,
   output logic cfgRdValid,
   input wire bridge_evt_t evt,
   output bridge_ctl_t ctl,
   output logic [15:0] primary_command,
   output logic [15:0] primary_status
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic [15:0] cmdReg;
   logic [15:0] stickyFlags;
   wire logic cmdHit = cfgReq.addr == CMD_OFFSET;
   wire logic stsHit = cfgReq.addr == STS_OFFSET;
   wire logic [15:0] laneMask = {{8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
   wire logic cmdWrite = cfgReq.wrEn && cmdHit;
   wire logic stsWrite = cfgReq.wrEn && stsHit;

   // ----------------------------------------
   // Command register
   // ----------------------------------------
   // Only writable bits change; the rest stay zero without any error
   wire logic [15:0] cmdWrMask = CMD_WMASK & laneMask;
   wire logic [15:0] next_cmdReg = (cmdReg & ~cmdWrMask) | (cfgReq.wrData & cmdWrMask);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmdReg <= CMD_RESET;
      end else if (cmdWrite) begin
         cmdReg <= next_cmdReg;
      end
   end

   // Bits 15:11, 10, 9, 7, 5, 3 are masked out of the stored value
   assign primary_command = cmdReg & CMD_WMASK;

   wire logic errFwd = cmdReg[ERR_FWD_BIT];
   wire logic parResp = cmdReg[PAR_RESP_BIT];
   wire logic wrInv = cmdReg[WR_INV_BIT];
   wire logic master = cmdReg[MASTER_BIT];
   wire logic memDec = cmdReg[MEM_BIT];
   wire logic ioDec = cmdReg[IO_BIT];

   // ----------------------------------------
   // Status register
   // ----------------------------------------
   wire logic errMsg = evt.secSerr && errFwd;
   wire logic [15:0] setBits = ({15'h0000, 1'b0} |
      (16'(evt.poisonedRx) << DET_PAR_BIT) |
      (16'(errMsg) << SIG_ERR_BIT) |
      (16'(parResp && (evt.poisonedCpl || evt.poisonedWrite)) << MPAR_BIT));
   wire logic [15:0] clearBits = stsWrite ? (cfgReq.wrData & laneMask & STS_W1C_MASK)
                                          : 16'h0000;

   status_flags #(.WIDTH(16)) flagsInst (
      .sys_clk(sys_clk),
      .reset(reset),
      .setBits(setBits),
      .clearBits(clearBits),
      .flags(stickyFlags)
   );

   // Bit 4 is the hardwired capabilities-list indicator
   assign primary_status = (stickyFlags & STS_W1C_MASK) | STS_RESET;

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   wire logic [15:0] rdMux = cmdHit ? primary_command :
                             stsHit ? primary_status : 16'h0000;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfgRdData <= 16'h0000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdData <= cfgReq.rdEn ? rdMux : 16'h0000;
         cfgRdValid <= cfgReq.rdEn;
      end
   end

   // ----------------------------------------
   // Gating toward the link and the secondary bus
   // ----------------------------------------
   assign ctl.memForward = evt.downMemReq && memDec;
   assign ctl.memUnsupported = evt.downMemReq && !memDec;
   assign ctl.ioForward = evt.downIoReq && ioDec;
   assign ctl.ioUnsupported = evt.downIoReq && !ioDec;
   assign ctl.useWriteInvalidate = evt.downMemWrite && memDec && wrInv;
   // Poison always goes down with bad parity; the enable only steers the flag
   assign ctl.forcedBadParity = evt.poisonedRx;
   assign ctl.claimSecondary = evt.secMemIoReq && master;
   assign ctl.upReqGrant = evt.upReq && master;
   assign ctl.errMsgSend = errMsg;
   assign ctl.specialClaim = 1'b0;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence cmdWriteAll_s;
      cfgReq.wrEn && cmdHit && cfgReq.byteEn == 2'b11;
   endsequence

   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_command[15:11] == 5'h00) else $error("reserved command bits nonzero");
   fixed_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
      !primary_command[10] && !primary_command[9] && !primary_command[7] &&
      !primary_command[5] && !primary_command[3]) else $error("hardwired bit set");
   rw_update_a: assert property (@(posedge sys_clk) disable iff (reset)
      cmdWriteAll_s |=> primary_command == ($past(cfgReq.wrData) & CMD_WMASK))
      else $error("command write not stored");
   cmd_reset_a: assert property (@(posedge sys_clk)
      reset |=> primary_command == 16'h0000 && primary_status == 16'h0010)
      else $error("wrong reset value");
   mem_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.downMemReq |-> (ctl.memUnsupported == !primary_command[1]) &&
      ctl.memForward != ctl.memUnsupported)
      else $error("memory gating wrong");
   io_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.downIoReq && !primary_command[0] |-> ctl.ioUnsupported && !ctl.ioForward)
      else $error("io gating wrong");
   master_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
      !primary_command[2] |-> !ctl.upReqGrant && !ctl.claimSecondary)
      else $error("master disabled but active");
   poison_par_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.poisonedRx |-> ctl.forcedBadParity) else $error("poison not forwarded");
   mpar_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      parResp && evt.poisonedCpl |=> primary_status[8]) else $error("parity flag missed");
   mpar_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      !primary_status[8] && !parResp |=> !primary_status[8]) else $error("parity flag leaked");
   sig_err_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.secSerr && errFwd |-> ctl.errMsgSend ##1 primary_status[14])
      else $error("signaled error missed");
   err_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      !errFwd |-> !ctl.errMsgSend) else $error("error sent while disabled");
   mwi_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.downMemWrite && memDec |-> ctl.useWriteInvalidate == wrInv)
      else $error("write invalidate wrong");

   // ----------------------------------------
   // Access and event sequences
   // ----------------------------------------
   sequence cmdRead_s;
      cfgReq.rdEn && cmdHit;
   endsequence

   sequence stsRead_s;
      cfgReq.rdEn && stsHit;
   endsequence

   sequence cmdWriteLow_s;
      cfgReq.wrEn && cmdHit && cfgReq.byteEn == 2'b01;
   endsequence

   sequence cmdWriteHigh_s;
      cfgReq.wrEn && cmdHit && cfgReq.byteEn == 2'b10;
   endsequence

   sequence stsClearAll_s;
      cfgReq.wrEn && stsHit && cfgReq.byteEn == 2'b11;
   endsequence

   sequence poison_s;
      evt.poisonedRx;
   endsequence

   sequence serrFwd_s;
      evt.secSerr && errFwd;
   endsequence

   // ----------------------------------------
   // Read path and status checks
   // ----------------------------------------
   cmd_read_a: assert property (@(posedge sys_clk) disable iff (reset)
      cmdRead_s |=> cfgRdValid && cfgRdData == $past(primary_command))
      else $error("command read wrong");

   sts_read_a: assert property (@(posedge sys_clk) disable iff (reset)
      stsRead_s |=> cfgRdValid && cfgRdData == $past(primary_status))
      else $error("status read wrong");

   read_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !cfgReq.rdEn |=> !cfgRdValid && cfgRdData == 16'h0000)
      else $error("read data without request");

   unmapped_read_a: assert property (@(posedge sys_clk) disable iff (reset)
      cfgReq.rdEn && !cmdHit && !stsHit |=> cfgRdData == 16'h0000)
      else $error("unmapped read nonzero");

   cmd_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      !cmdWrite |=> $stable(primary_command))
      else $error("command changed without write");

   upper_lane_a: assert property (@(posedge sys_clk) disable iff (reset)
      cmdWriteLow_s |=> primary_command[15:8] == $past(primary_command[15:8]))
      else $error("upper byte written without enable");

   lower_lane_a: assert property (@(posedge sys_clk) disable iff (reset)
      cmdWriteHigh_s |=> primary_command[7:0] == $past(primary_command[7:0]))
      else $error("lower byte written without enable");

   read_reset_a: assert property (@(posedge sys_clk)
      reset |=> !cfgRdValid && cfgRdData == 16'h0000)
      else $error("read path not cleared by reset");

   sts_bit4_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_status[4])
      else $error("capability bit clear");

   sts_fixed_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_status[13:9] == 5'h00 && primary_status[7:5] == 3'h0 && primary_status[3:0] == 4'h0)
      else $error("fixed status bit set");

   det_par_a: assert property (@(posedge sys_clk) disable iff (reset)
      poison_s |=> primary_status[15])
      else $error("detected parity flag missed");

   sts_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      stsClearAll_s ##0 (cfgReq.wrData == 16'hFFFF && setBits == 16'h0000) |=> primary_status == 16'h0010)
      else $error("status clear failed");

   sig_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_status[14] && !stsWrite |=> primary_status[14])
      else $error("signaled error flag lost");

   mpar_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_status[8] && !stsWrite |=> primary_status[8])
      else $error("parity flag lost");

   det_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_status[15] && !stsWrite |=> primary_status[15])
      else $error("detected parity flag lost");

   sig_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      !primary_status[14] && !errFwd |=> !primary_status[14])
      else $error("signaled error flag leaked");

   mpar_wr_a: assert property (@(posedge sys_clk) disable iff (reset)
      parResp && evt.poisonedWrite |=> primary_status[8])
      else $error("parity flag missed on write");

   // ----------------------------------------
   // Gating checks
   // ----------------------------------------
   mem_fwd_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.downMemReq && primary_command[1] |-> ctl.memForward && !ctl.memUnsupported)
      else $error("memory not forwarded");

   mem_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !evt.downMemReq |-> !ctl.memForward && !ctl.memUnsupported)
      else $error("memory decision without request");

   io_fwd_a: assert property (@(posedge sys_clk) disable iff (reset)
      evt.downIoReq && primary_command[0] |-> ctl.ioForward && !ctl.ioUnsupported)
      else $error("io not forwarded");

   io_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !evt.downIoReq |-> !ctl.ioForward && !ctl.ioUnsupported)
      else $error("io decision without request");

   master_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_command[2] && evt.upReq |-> ctl.upReqGrant)
      else $error("upstream request not granted");

   claim_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      primary_command[2] && evt.secMemIoReq |-> ctl.claimSecondary)
      else $error("secondary request not claimed");

   special_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      !ctl.specialClaim)
      else $error("special cycle claimed");

   mwi_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      !primary_command[4] |-> !ctl.useWriteInvalidate)
      else $error("promotion while disabled");

   mwi_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !evt.downMemWrite |-> !ctl.useWriteInvalidate)
      else $error("promotion without write");

   err_send_a: assert property (@(posedge sys_clk) disable iff (reset)
      serrFwd_s |-> ctl.errMsgSend)
      else $error("error message not sent");

   err_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !evt.secSerr |-> !ctl.errMsgSend)
      else $error("error message without cause");

   parity_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !evt.poisonedRx |-> !ctl.forcedBadParity)
      else $error("bad parity without poison");

   err_flag_seq_a: assert property (@(posedge sys_clk) disable iff (reset)
      serrFwd_s ##1 !stsWrite |=> primary_status[14])
      else $error("signaled error flag not kept");
endmodule

// File: tb/bridge_link_model.sv
// Far-side event source standing for the upstream link and secondary bus
`timescale 1ns/100ps
module bridge_link_model
   import cmd_status_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic fire,
   output bridge_evt_t evt
);
   // ----------------------------------------
   // Event pulses
   // ----------------------------------------
   // All events at once for one cycle: the harshest case for the gating logic
   always_ff @(posedge sys_clk) begin
      if (reset || !fire) begin
         evt <= '0;
      end else begin
         evt <= '1;
      end
   end
endmodule

// File: tb/tb_bridge_command_status_regs.sv
// Self-checking testbench for the bridge command and status registers
`timescale 1ns/100ps
module tb_bridge_command_status_regs
   import cmd_status_pkg::*;
;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic sys_clk;
   logic reset;
   logic fire;
   cfg_req_t cfgReq;
   logic [15:0] cfgRdData;
   logic cfgRdValid;
   bridge_evt_t evt;
   bridge_ctl_t ctl;
   logic [15:0] primaryCommand;
   logic [15:0] primaryStatus;
   int errTotal;
   int checkCount;
   int cycles;

   bridge_command_status_regs uut (
      .sys_clk(sys_clk),
      .reset(reset),
      .cfgReq(cfgReq),
      .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid),
      .evt(evt),
      .ctl(ctl),
      .primary_command(primaryCommand),
      .primary_status(primaryStatus)
   );

   bridge_link_model partner (
      .sys_clk(sys_clk),
      .reset(reset),
      .fire(fire),
      .evt(evt)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic endSim;
      $display("Checks %0d, errors %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cfgWrite(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge sys_clk);
      cfgReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, byteEn: be, wrData: d};
      @(posedge sys_clk);
      cfgReq <= '0;
   endtask

   // A missing valid pulse turns the data into a value no register can hold
   task automatic rdCheck(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      cfgReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, byteEn: 2'h3, wrData: 16'h0000};
      @(posedge sys_clk);
      cfgReq <= '0;
      @(negedge sys_clk);
      check((cfgRdValid === 1'b1) ? cfgRdData : 16'hDEAD, exp);
   endtask

   task automatic burst(input logic [9:0] expCtl);
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      @(negedge sys_clk);
      check({6'h00, ctl}, {6'h00, expCtl});
   endtask

   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errTotal++;
         endSim;
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      cfgReq = '0;
      fire = 1'b0;
      reset = 1'b1;
      errTotal = 0;
      checkCount = 0;
      cycles = 0;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rdCheck(CMD_OFFSET, 16'h0000);
      rdCheck(STS_OFFSET, 16'h0010);
      rdCheck(8'h08, 16'h0000);
      burst(10'h150);
      rdCheck(STS_OFFSET, 16'h8010);
      cfgWrite(STS_OFFSET, 2'h3, 16'hFFFF);
      rdCheck(STS_OFFSET, 16'h0010);
      cfgWrite(CMD_OFFSET, 2'h1, 16'hFFFF);
      @(negedge sys_clk);
      check(primaryCommand, 16'h0057);
      cfgWrite(CMD_OFFSET, 2'h3, 16'hFFFF);
      rdCheck(CMD_OFFSET, 16'h0157);
      burst(10'h2BE);
      rdCheck(STS_OFFSET, 16'hC110);
      cfgWrite(CMD_OFFSET, 2'h3, 16'h0000);
      burst(10'h150);
      endSim;
   end
endmodule
